//--- logic/request_issuer.sv
`timescale 1ns/1ps
// Contract
// - unconstrained requests may follow with zero cycles spacing.
// - spacing counts from effective position, packet plus delay.
// - open, read, store, close classes are spacing equivalents.
// - open-to-open different banks needs the open-to-open gap.
// - open then same-bank read or store waits its gap.
// - close follows same-bank open by the open-to-close minimum.
// - read-read and store-store need the column gap.
// - store after read waits the read-to-store turnaround.
// - read after store waits the store-to-read turnaround.
// - close follows same-bank read by the read-to-close gap.
// - close follows same-bank store by the store-to-close gap.
// - close-close needs close gap, same bank needs bank cycle.
// - open follows same-bank close by the close-to-open gap.
// - read or store then open same bank needs a close between.
// - close then read or store same bank needs an open between.
module request_issuer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire req_pkg::user_req_s req,
  output logic req_ready,
  output logic req_reject,
  output logic [11:0] rq_pins,
  output logic rq_pins_valid,
  output logic [10:0] refresh_row_regs,
  output logic cal_active,
  output logic powered_down
);
  import req_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DOWN = 3'b100
  } st_e;

  typedef struct packed {
    st_e st;
    logic [5:0] now;
    logic [NBANK-1:0][5:0] open_t;
    logic [NBANK-1:0][5:0] close_t;
    logic [NBANK-1:0][5:0] rd_t;
    logic [NBANK-1:0][5:0] wr_t;
    logic [NBANK-1:0] is_open;
    logic [NBANK-1:0] touched;
    logic [5:0] last_open;
    logic [5:0] last_close;
    logic [5:0] last_rd;
    logic [5:0] last_wr;
    logic [3:0] seen;
    logic [11:0] word;
    logic tog;
    logic a1;
    logic a2;
    logic a3;
    logic ready;
    logic reject;
    logic [10:0] ref_row;
    logic cal;
    logic down;
  } iss_state_s;

  iss_state_s s_q;
  iss_state_s s_d;
  rq_word_s link_word;
  logic ack_tog;

  // compare elapsed time since a stamp to a gap; counters wrap so stamps saturate in use
  function automatic logic gap_ok(input logic [5:0] now, input logic [5:0] t,
                                  input logic [5:0] gap, input logic seen);
    logic [5:0] el;
    el = 6'(now - t);
    gap_ok = !seen || (el >= gap);
  endfunction

  // old stamps follow now at a fixed age so 6-bit wrap never fakes a recent event
  function automatic logic [5:0] age_cap(input logic [5:0] now, input logic [5:0] t);
    age_cap = (6'(now - t) == AGE_CAP) ? 6'(t + 6'h01) : t;
  endfunction

  function automatic logic legal_code(input user_req_s r);
    legal_code = 1'b1;
    if (r.cls == CLS_CLOSE && r.sub != precharge_idle_code && !r.sub[2])
      legal_code = 1'b0;
    if (r.cls == CLS_MAINT && !(r.xsub == current_cal_cmd || r.xsub == impedance_cal_cmd ||
        r.xsub == end_cal_cmd || r.xsub == powerdown_entry_cmd))
      legal_code = 1'b0;
  endfunction

  logic spacing_ok;
  logic [5:0] eff;
  logic [11:0] word_c;
  logic [2:0] b;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    b = req.bank;
    eff = 6'(s_q.now + 6'(req.delay));
    spacing_ok = 1'b1;
    word_c = 12'h000;
    case (req.cls)
      CLS_OPEN: begin
        spacing_ok = gap_ok(eff, s_q.last_open, open_to_open_gap, s_q.seen[0])
          && gap_ok(eff, s_q.close_t[b], CLOSE_TO_OPEN_GAP, s_q.touched[b])
          && gap_ok(eff, s_q.close_t[b], bank_cycle_gap - open_to_close_min,
                    s_q.touched[b])
          && !s_q.is_open[b];
        word_c = {OP_OPEN[3:2], req.delay[0], b, req.addr[5:0]};
      end
      CLS_READ: begin
        spacing_ok = gap_ok(eff, s_q.open_t[b], OPEN_TO_READ_GAP, 1'b1)
          && gap_ok(eff, s_q.last_rd, column_to_column_gap, s_q.seen[1])
          && gap_ok(eff, s_q.last_wr, STORE_TO_READ_GAP, s_q.seen[2])
          && s_q.is_open[b];
        word_c = {OP_COL, 1'b0, req.delay[0], req.addr[2:0], b};
      end
      CLS_STORE: begin
        spacing_ok = gap_ok(eff, s_q.open_t[b], OPEN_TO_STORE_GAP, 1'b1)
          && gap_ok(eff, s_q.last_wr, column_to_column_gap, s_q.seen[2])
          && gap_ok(eff, s_q.last_rd, READ_TO_STORE_GAP, s_q.seen[1])
          && s_q.is_open[b];
        word_c = req.sub[0] ? {OP_MASKED[3], req.addr[7:0], b}
                            : {OP_COL, 1'b1, req.delay[0], req.addr[2:0], b};
      end
      CLS_CLOSE: begin
        if (req.sub[2]) begin
          eff = 6'(s_q.now + 6'(req.sub[1:0]));
          spacing_ok = gap_ok(eff, s_q.open_t[b], open_to_close_min, s_q.is_open[b])
            && gap_ok(eff, s_q.rd_t[b], read_to_close_gap, s_q.is_open[b])
            && gap_ok(eff, s_q.wr_t[b], store_to_close_gap, s_q.is_open[b])
            && gap_ok(eff, s_q.last_close, CLOSE_TO_CLOSE_GAP, s_q.seen[3])
            && gap_ok(eff, s_q.close_t[b], bank_cycle_gap, s_q.touched[b]);
        end
        // precharge and refresh fields share one packet
        word_c = {OP_CLOSE[1:0], req.addr[9:8], req.sub, req.addr[1:0], b};
      end
      CLS_MAINT: begin
        word_c = {OP_EXT, 4'h0, req.xsub};
      end
      default: spacing_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.a1 = ack_tog;
    s_d.a2 = s_q.a1;
    s_d.a3 = s_q.a2;
    s_d.now = 6'(s_q.now + 6'h01);
    for (int i = 0; i < NBANK; i++) begin
      s_d.open_t[i] = age_cap(s_q.now, s_q.open_t[i]);
      s_d.close_t[i] = age_cap(s_q.now, s_q.close_t[i]);
      s_d.rd_t[i] = age_cap(s_q.now, s_q.rd_t[i]);
      s_d.wr_t[i] = age_cap(s_q.now, s_q.wr_t[i]);
    end
    s_d.last_open = age_cap(s_q.now, s_q.last_open);
    s_d.last_close = age_cap(s_q.now, s_q.last_close);
    s_d.last_rd = age_cap(s_q.now, s_q.last_rd);
    s_d.last_wr = age_cap(s_q.now, s_q.last_wr);
    s_d.reject = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid) begin
          if (!legal_code(req) || !spacing_ok) begin
            s_d.reject = 1'b1;
          end else begin
            s_d.word = word_c;
            s_d.tog = !s_q.tog;
            s_d.ready = 1'b0;
            s_d.st = ST_WAIT;
            case (req.cls)
              CLS_OPEN: begin
                s_d.open_t[b] = eff;
                s_d.last_open = eff;
                s_d.is_open[b] = 1'b1;
                s_d.seen[0] = 1'b1;
              end
              CLS_READ: begin
                s_d.rd_t[b] = eff;
                s_d.last_rd = eff;
                s_d.seen[1] = 1'b1;
              end
              CLS_STORE: begin
                s_d.wr_t[b] = eff;
                s_d.last_wr = eff;
                s_d.seen[2] = 1'b1;
              end
              CLS_CLOSE: begin
                if (req.sub[2]) begin
                  s_d.close_t[b] = eff;
                  s_d.last_close = eff;
                  s_d.is_open[b] = 1'b0;
                  s_d.touched[b] = 1'b1;
                  s_d.seen[3] = 1'b1;
                end
                if (req.sub[1:0] == 2'h0 && req.addr[10:8] == refresh_open_incr_cmd)
                  s_d.ref_row = 11'(s_q.ref_row + 11'h001);
              end
              CLS_MAINT: begin
                if (req.xsub == current_cal_cmd) s_d.cal = 1'b1;
                if (req.xsub == end_cal_cmd) s_d.cal = 1'b0;
                if (req.xsub == powerdown_entry_cmd) s_d.down = 1'b1;
              end
              default: s_d.seen = s_q.seen;
            endcase
          end
        end
      end
      ST_WAIT: begin
        if (s_q.a3 == s_q.tog)
          s_d.st = s_q.down ? ST_DOWN : ST_IDLE;
      end
      ST_DOWN: begin
        // leaving power-down is outside this block; reset only
        s_d.ready = 1'b0;
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (reset) begin
      s_d = '0;
      s_d.st = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en || reset) begin
      s_q <= s_d;
    end
  end

  link_side u_link (
    .link_clk(link_clk),
    .reset(reset),
    .tog_in(s_q.tog),
    .word_in('{valid: 1'b1, word: s_q.word}),
    .rq_out(link_word),
    .ack_tog(ack_tog)
  );

  assign req_ready = s_q.ready;
  assign req_reject = s_q.reject;
  assign refresh_row_regs = s_q.ref_row;
  assign cal_active = s_q.cal;
  assign powered_down = s_q.down;
  assign rq_pins = link_word.word;
  assign rq_pins_valid = link_word.valid;

  a_toggle_held: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_WAIT && clk_en) |=> $stable(s_q.tog)) else $error("toggle moved in wait");
  a_reject_spacing: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && s_q.st == ST_IDLE && req_valid && !spacing_ok) |=> req_reject)
    else $error("spacing breach not refused");
  a_no_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && s_q.st == ST_IDLE && req_valid && !legal_code(req)) |=> !$changed(s_q.tog))
    else $error("reserved code issued");
  a_open_marks: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && s_q.st == ST_IDLE && req_valid && req.cls == CLS_READ && !s_q.is_open[req.bank])
    |=> req_reject) else $error("read to closed bank");
  a_pdn_stays: assert property (@(posedge ref_clk) disable iff (reset)
    powered_down |=> powered_down) else $error("power-down dropped");
  a_cal_end: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && s_q.st == ST_IDLE && req_valid && legal_code(req) && req.cls == CLS_MAINT
     && req.xsub == end_cal_cmd) |=> !cal_active) else $error("calibration not ended");
  a_close_gap: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_en && s_q.st == ST_IDLE && req_valid && req.cls == CLS_CLOSE && req.sub[2]
     && s_q.is_open[req.bank] && 6'(eff - s_q.open_t[req.bank]) < open_to_close_min)
    |=> req_reject) else $error("early close accepted");
  a_idle_ready: assert property (@(posedge ref_clk) disable iff (reset)
    (s_q.st == ST_WAIT) |-> !req_ready) else $error("ready while busy");

endmodule

//--- pkg/req_pkg.sv
package req_pkg;

  // request packet geometry
  localparam int unsigned RQ_W = 12;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned NBANK = 8;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned COL_W = 6;
  localparam int unsigned REF_ROW_BITS = 11;

  // opcode field positions
  localparam int unsigned OP_LSB = 8;
  localparam int unsigned POP_LSB = 5;
  localparam int unsigned BP_LSB = 0;
  localparam int unsigned ROP_LSB = 8;
  localparam int unsigned RA_LSB = 0;
  localparam int unsigned XOP_LSB = 0;

  // packet opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_COL = 4'h1;
  localparam logic [3:0] OP_EXT = 4'h2;
  localparam logic [3:0] OP_CLOSE = 4'h3;
  localparam logic [3:0] OP_OPEN = 4'h4;
  localparam logic [3:0] OP_MASKED = 4'h8;

  // precharge sub-codes
  localparam logic [2:0] precharge_idle_code = 3'h0;
  localparam logic [2:0] POP_PRE_BASE = 3'h4;

  // extended sub-codes
  localparam logic [3:0] current_cal_cmd = 4'h8;
  localparam logic [3:0] impedance_cal_cmd = 4'h9;
  localparam logic [3:0] end_cal_cmd = 4'ha;
  localparam logic [3:0] powerdown_entry_cmd = 4'hc;

  // refresh sub-codes
  localparam logic [2:0] refresh_close_cmd = 3'h1;
  localparam logic [2:0] refresh_open_cmd = 3'h2;
  localparam logic [2:0] refresh_open_incr_cmd = 3'h3;

  // spacing gaps in request cycles
  localparam int unsigned GAP_W = 6;
  localparam logic [5:0] open_to_open_gap = 6'h02;
  localparam logic [5:0] OPEN_TO_READ_GAP = 6'h03;
  localparam logic [5:0] OPEN_TO_STORE_GAP = 6'h02;
  localparam logic [5:0] open_to_close_min = 6'h05;
  localparam logic [5:0] column_to_column_gap = 6'h01;
  localparam logic [5:0] READ_TO_STORE_GAP = 6'h03;
  localparam logic [5:0] STORE_TO_READ_GAP = 6'h03;
  localparam logic [5:0] read_to_close_gap = 6'h02;
  localparam logic [5:0] store_to_close_gap = 6'h03;
  localparam logic [5:0] CLOSE_TO_CLOSE_GAP = 6'h01;
  localparam logic [5:0] bank_cycle_gap = 6'h08;
  localparam logic [5:0] CLOSE_TO_OPEN_GAP = 6'h03;
  // stamp age held here; well above every gap plus the longest delay
  localparam logic [5:0] AGE_CAP = 6'h20;

  typedef enum logic [2:0] {
    CLS_OPEN = 3'h0,
    CLS_READ = 3'h1,
    CLS_STORE = 3'h2,
    CLS_CLOSE = 3'h3,
    CLS_MAINT = 3'h4
  } cmd_class_e;

  // one user request
  typedef struct packed {
    cmd_class_e cls;
    logic [2:0] sub;
    logic [2:0] bank;
    logic [11:0] addr;
    logic [1:0] delay;
    logic [3:0] xsub;
  } user_req_s;

  typedef struct packed {
    logic valid;
    logic [11:0] word;
  } rq_word_s;

endpackage

//--- logic/link_side.sv
`timescale 1ns/1ps
module link_side (
  input wire logic link_clk,
  input wire logic reset,
  input wire logic tog_in,
  input wire req_pkg::rq_word_s word_in,
  output req_pkg::rq_word_s rq_out,
  output logic ack_tog
);
  import req_pkg::*;

  typedef struct packed {
    logic rst1;
    logic rst2;
    logic t1;
    logic t2;
    logic t3;
    rq_word_s rq;
  } link_state_s;

  link_state_s s_q;
  link_state_s s_d;

  // request word is held stable by the sender until ack returns
  always_comb begin
    s_d = s_q;
    s_d.rst1 = reset;
    s_d.rst2 = s_q.rst1;
    s_d.t1 = tog_in;
    s_d.t2 = s_q.t1;
    s_d.t3 = s_q.t2;
    s_d.rq = '{valid: 1'b0, word: 12'h000};
    if (s_q.t2 != s_q.t3) begin
      s_d.rq = word_in;
      s_d.rq.valid = 1'b1;
    end
    if (s_q.rst2) begin
      s_d.t1 = 1'b0;
      s_d.t2 = 1'b0;
      s_d.t3 = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    s_q <= s_d;
  end

  assign rq_out = s_q.rq;
  assign ack_tog = s_q.t3;

endmodule

//--- tb/device_model.sv
`timescale 1ns/1ps
module device_model (
  input wire logic link_clk,
  input wire logic [11:0] rq_pins,
  input wire logic rq_pins_valid,
  output int word_count,
  output logic cal_on,
  output logic pdn_on
);
  import req_pkg::*;
  logic [3:0] op;
  logic [2:0] pop;
  logic [2:0] pre_bank;
  logic [2:0] ref_bank;
  logic [REF_ROW_BITS-1:0] ref_row;
  logic [7:0] open_banks;
  assign op = rq_pins[OP_LSB +: 4];
  assign pop = rq_pins[POP_LSB +: 3];
  assign pre_bank = rq_pins[BP_LSB +: 3];
  assign ref_bank = rq_pins[RA_LSB +: 3];
  initial begin
    word_count = 0;
    cal_on = 1'b0;
    pdn_on = 1'b0;
    ref_row = '0;
    open_banks = '0;
  end
  // one word per request cycle; a reserved code falls through as a no-op
  always @(posedge link_clk) begin
    if (rq_pins_valid === 1'b1) begin
      word_count <= word_count + 1;
      if (op == OP_OPEN)
        open_banks[pre_bank] <= 1'b1;
      if (op == OP_CLOSE && pop[2])
        open_banks[pre_bank] <= 1'b0;
      if (op == OP_EXT) begin
        case (rq_pins[XOP_LSB +: 4])
          current_cal_cmd: cal_on <= 1'b1;
          end_cal_cmd: cal_on <= 1'b0;
          powerdown_entry_cmd: pdn_on <= 1'b1;
          default: ;
        endcase
      end
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import req_pkg::*;
  logic ref_clk = 0;
  logic link_clk = 0;
  logic reset = 1;
  logic clk_en = 1;
  logic req_valid = 0;
  user_req_s req = '0;
  logic req_ready, req_reject, rq_pins_valid, cal_active, powered_down;
  logic [11:0] rq_pins;
  logic [10:0] refresh_row_regs;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int accepted = 0;
  int words;
  logic m_cal, m_pdn;
  bit open_q[8];
  logic exp_cal = 0;
  int now_c = 0;
  int exp_row = 0;
  int t_open[8] = '{default: -1000};
  int t_close[8] = '{default: -1000};
  int t_rd[8] = '{default: -1000};
  int t_wr[8] = '{default: -1000};
  int l_open = -1000;
  int l_close = -1000;
  int l_rd = -1000;
  int l_wr = -1000;

  always #10 ref_clk = ~ref_clk;
  // link clock offset so its edges never line up with ref_clk
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  request_issuer request_issuer_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .link_clk(link_clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_reject(req_reject), .rq_pins(rq_pins), .rq_pins_valid(rq_pins_valid),
    .refresh_row_regs(refresh_row_regs), .cal_active(cal_active),
    .powered_down(powered_down));
  device_model device_model_i (.link_clk(link_clk), .rq_pins(rq_pins),
    .rq_pins_valid(rq_pins_valid), .word_count(words), .cal_on(m_cal), .pdn_on(m_pdn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (reset) now_c = 0;
    else if (clk_en) now_c++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // spacing in enabled request cycles, from effective positions
  function automatic bit refused(cmd_class_e c, logic [2:0] sub, logic [2:0] b, logic [3:0] x,
                                 logic [1:0] d);
    int e;
    e = now_c + ((c == CLS_CLOSE) ? int'(sub[1:0]) : int'(d));
    case (c)
      CLS_OPEN: return open_q[b]
        || e - l_open < int'(open_to_open_gap)
        || e - t_close[b] < int'(CLOSE_TO_OPEN_GAP)
        || e - t_close[b] < int'(bank_cycle_gap) - int'(open_to_close_min);
      CLS_READ: return !open_q[b] || e - t_open[b] < int'(OPEN_TO_READ_GAP)
        || e - l_rd < int'(column_to_column_gap)
        || e - l_wr < int'(STORE_TO_READ_GAP);
      CLS_STORE: return !open_q[b] || e - t_open[b] < int'(OPEN_TO_STORE_GAP)
        || e - l_wr < int'(column_to_column_gap)
        || e - l_rd < int'(READ_TO_STORE_GAP);
      CLS_CLOSE: return (sub inside {3'h1, 3'h2, 3'h3}) || (sub[2] && (
        (open_q[b] && (e - t_open[b] < int'(open_to_close_min)
        || e - t_rd[b] < int'(read_to_close_gap)
        || e - t_wr[b] < int'(store_to_close_gap)))
        || e - l_close < int'(CLOSE_TO_CLOSE_GAP)
        || e - t_close[b] < int'(bank_cycle_gap)));
      default: return !(x inside {current_cal_cmd, impedance_cal_cmd, end_cal_cmd,
                                  powerdown_entry_cmd});
    endcase
  endfunction

  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  // behavioural bank model decides refusal; design must agree
  task automatic issue(cmd_class_e c, logic [2:0] sub, logic [2:0] b, logic [3:0] x,
                       logic [2:0] rop = 3'h0);
    bit exp_rej;
    logic rej;
    int e;
    wait_ready();
    repeat ($urandom_range(2)) begin
      clk_en = 0;
      @(posedge ref_clk);
      #1;
    end
    clk_en = 1;
    req.cls = c;
    req.sub = sub;
    req.bank = b;
    // refresh sub-code idle unless asked, so only precharge touches bank state
    req.addr = (c == CLS_CLOSE) ? {1'b0, rop, 8'($urandom)} : 12'($urandom);
    req.delay = 2'($urandom);
    req.xsub = x;
    exp_rej = refused(c, sub, b, x, req.delay);
    e = now_c + ((c == CLS_CLOSE) ? int'(sub[1:0]) : int'(req.delay));
    req_valid = 1;
    @(posedge ref_clk);
    #1;
    req_valid = 0;
    rej = req_reject;
    @(posedge ref_clk);
    #1;
    rej = rej | req_reject;
    check("reject", {31'h0, rej}, {31'h0, exp_rej});
    if (!exp_rej) begin
      accepted++;
      case (c)
        CLS_OPEN: begin
          open_q[b] = 1;
          t_open[b] = e;
          l_open = e;
        end
        CLS_READ: begin
          t_rd[b] = e;
          l_rd = e;
        end
        CLS_STORE: begin
          t_wr[b] = e;
          l_wr = e;
        end
        CLS_CLOSE: begin
          if (sub[2]) begin
            open_q[b] = 0;
            t_close[b] = e;
            l_close = e;
          end
          if (sub[1:0] == 2'h0 && rop == refresh_open_incr_cmd) exp_row++;
        end
        CLS_MAINT: if (x == current_cal_cmd) exp_cal = 1; else if (x == end_cal_cmd) exp_cal = 0;
        default: ;
      endcase
      if (!(c == CLS_MAINT && x == powerdown_entry_cmd)) begin
        wait_ready();
        check("cal_active", {31'h0, cal_active}, {31'h0, exp_cal});
        check("cal_model", {31'h0, m_cal}, {31'h0, exp_cal});
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] x;
    void'($urandom(32'hbbda4b88));
    repeat (16) @(posedge ref_clk);
    #1;
    check("ready_rst", {31'h0, req_ready}, 32'h0);
    check("ref_row_rst", {21'h0, refresh_row_regs}, 32'h0);
    check("pdn_rst", {31'h0, powered_down}, 32'h0);
    reset = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("ready", {31'h0, req_ready}, 32'h1);
    // every precharge sub-code; read after shows whether the bank closed
    for (int i = 0; i < 8; i++) begin
      issue(CLS_OPEN, 3'h0, 3'(i), 4'h0);
      issue(CLS_CLOSE, 3'(i), 3'(i), 4'h0);
      issue(CLS_READ, 3'h0, 3'(i), 4'h0);
    end
    // every extended sub-code except power-down
    for (int i = 0; i < 16; i++)
      if (4'(i) != powerdown_entry_cmd) issue(CLS_MAINT, 3'h0, 3'h0, 4'(i));
    // refresh-increment riding with and without a precharge
    issue(CLS_CLOSE, 3'h0, 3'h1, 4'h0, refresh_open_incr_cmd);
    issue(CLS_CLOSE, 3'h4, 3'h2, 4'h0, refresh_open_incr_cmd);
    check("ref_row", {21'h0, refresh_row_regs}, 32'(exp_row));
    repeat (60) begin
      x = 4'($urandom);
      if (x == powerdown_entry_cmd) x = impedance_cal_cmd;
      issue(cmd_class_e'($urandom_range(4)), 3'($urandom), 3'($urandom), x);
    end
    repeat (20) @(posedge link_clk);
    #1;
    check("words", 32'(words), 32'(accepted));
    issue(CLS_MAINT, 3'h0, 3'h0, powerdown_entry_cmd);
    repeat (40) @(posedge ref_clk);
    #1;
    check("powered_down", {31'h0, powered_down}, 32'h1);
    check("ready_pdn", {31'h0, req_ready}, 32'h0);
    check("pdn_word", {31'h0, m_pdn}, 32'h1);
    stop_test();
  end
endmodule
